// ==== core/cpu_operand_model.sv ====
// operand and register model of the 8-bit core with selectable instruction cycle
// Behaviour
// - instruction cycle is 4, 8, 16 or 64 main clock periods, selectable
// - bit-direct operand is 8-bit direct address plus 3-bit bit position
// - vector call carries 3-bit table number selecting a vector entry
// - relative branch adds 8-bit displacement to program counter
// - bank pointer is 5 bits and selects the general register bank
// - each bank holds eight 8-bit general registers, index 0 to 7
// - accumulator works as 8 or 16 bits with separate byte halves
// - temporary accumulator is 16 bits with byte halves, written only as a whole word by the 16-bit load
// - index register is 16 bits, used with 8-bit offset addressing
// - 16-bit extra pointer gives register-indirect memory access
// - program counter and stack pointer are each 16 bits
// - program status is 16 bits; condition flags are 8 bits
// - extended operand is 16 bits, reaching whole 64K space
// - only flag-affecting instructions update N, Z, V or C
// - serial shift clock period is at least two instruction cycles
// - immediate byte load sets N and Z; accumulator stores keep flags
`timescale 1ns/10ps
`default_nettype none
module cpu_operand_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_cycle_select,
  input wire logic i_op_valid,
  input wire cpu_operand_pkg::op_type i_op,
  input wire cpu_operand_pkg::vector_type i_vector_call,
  input wire logic [7:0] i_byte_operand,
  input wire logic [15:0] i_word_operand,
  input wire logic [2:0] i_reg_index,
  input wire logic [2:0] i_bit_pos,
  input wire logic [2:0] i_vector,
  input wire logic [4:0] i_bank,
  output logic o_ready,
  output logic o_done,
  output logic o_inst_tick,
  output logic o_serial_shift_clock,
  output logic [7:0] o_sum_high_byte,
  output logic [7:0] o_sum_low_byte,
  output logic [7:0] o_hold_high_byte,
  output logic [7:0] o_hold_low_byte,
  output logic [15:0] o_index_register,
  output logic [15:0] o_extra_pointer,
  output logic [15:0] o_program_counter,
  output logic [15:0] o_stack_pointer,
  output logic [15:0] o_program_status,
  output logic [7:0] o_condition_flags,
  output logic [4:0] o_bank_select_pointer,
  output logic o_mem_write,
  output logic [15:0] o_mem_addr,
  output logic [7:0] o_mem_data,
  output logic [2:0] o_bit_pos
);
  import cpu_operand_pkg::*;

  typedef enum logic [1:0] {st_idle, st_fetch, st_exec} phase_type;

  typedef struct packed {
    logic [6:0] cycle_count;
    logic inst_tick;
    logic shift_clock;
    phase_type phase;
    op_type op;
    vector_type vcall;
    logic [7:0] byte_op;
    logic [15:0] word_op;
    logic [2:0] reg_index;
    logic [2:0] bit_pos;
    logic [2:0] vector;
    logic [4:0] bank_in;
    logic [15:0] acc;
    logic [15:0] hold;
    logic [15:0] index_register;
    logic [15:0] extra_pointer;
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic [7:0] flags;
    logic [4:0] bank_select_pointer;
    logic gen_write;
    logic [7:0] gen_wdata;
    logic mem_write;
    logic [15:0] mem_addr;
    logic [7:0] mem_data;
    logic [2:0] mem_bit;
    logic done;
  } state_type;

  state_type state;
  state_type next_state;
  logic [7:0] gen_rdata;
  logic [GEN_ADDR_WIDTH-1:0] gen_addr;
  logic [6:0] cycle_div;
  logic [16:0] add_sum;
  logic [7:0] load_byte;

  // ==========================================================
  // general register storage
  assign gen_addr = {state.bank_select_pointer, state.reg_index};

  bank_reg_mem #(
    .ADDR_WIDTH(GEN_ADDR_WIDTH),
    .DATA_WIDTH(BYTE_WIDTH)
  ) u_bank_regs (
    .i_clk(i_clk),
    .i_addr(gen_addr),
    .i_wr_en(state.gen_write),
    .i_wr_data(state.gen_wdata),
    .o_rd_data(gen_rdata)
  );

  // ==========================================================
  // instruction cycle length selection
  always_comb
  begin
    case (i_cycle_select)
      2'h0: cycle_div = CYCLE_DIV_0;
      2'h1: cycle_div = CYCLE_DIV_1;
      2'h2: cycle_div = CYCLE_DIV_2;
      default: cycle_div = CYCLE_DIV_3;
    endcase
  end

  // ==========================================================
  // next state of divider, command capture and execution
  always_comb
  begin
    next_state = state;
    next_state.inst_tick = 1'b0;
    next_state.done = 1'b0;
    next_state.gen_write = 1'b0;
    next_state.mem_write = 1'b0;
    add_sum = {9'h000, state.acc[7:0]} + {9'h000, state.byte_op};
    load_byte = (state.op == op_mov_a_ri) ? gen_rdata : state.byte_op;
    // instruction cycle divider; shift clock toggles once per cycle
    if (state.cycle_count >= cycle_div - 7'h01)
    begin
      next_state.cycle_count = 7'h00;
      next_state.inst_tick = 1'b1;
      next_state.shift_clock = ~state.shift_clock;
    end
    else
    begin
      next_state.cycle_count = state.cycle_count + 7'h01;
    end
    case (state.phase)
      st_idle:
      begin
        if (i_op_valid)
        begin
          next_state.op = i_op;
          next_state.vcall = i_vector_call;
          next_state.byte_op = i_byte_operand;
          next_state.word_op = i_word_operand;
          next_state.reg_index = i_reg_index;
          next_state.bit_pos = i_bit_pos;
          next_state.vector = i_vector;
          next_state.bank_in = i_bank;
          next_state.phase = st_fetch;
        end
      end
      st_fetch:
      begin
        // one cycle lets the banked register read settle
        next_state.phase = st_exec;
      end
      default:
      begin
        if (state.inst_tick)
        begin
          next_state.phase = st_idle;
          next_state.done = 1'b1;
          if (state.vcall == op_vector_on)
          begin
            // lower stack pointer by STACK_STEP without storing a return address, jump to selected table entry address
            next_state.stack_pointer = state.stack_pointer - STACK_STEP;
            next_state.program_counter = VECTOR_BASE + {12'h000, state.vector, 1'b0};
          end
          else
          begin
            case (state.op)
              op_mov_a_imm8, op_mov_a_ri:
              begin
                // byte load into low half, flags N and Z follow the byte
                next_state.acc[7:0] = load_byte;
                next_state.flags[FLAG_N] = load_byte[7];
                next_state.flags[FLAG_Z] = (load_byte == 8'h00);
              end
              op_movw_a_imm16:
              begin
                // old accumulator moves to the temporary accumulator
                next_state.hold = state.acc;
                next_state.acc = state.word_op;
              end
              op_mov_ri_a:
              begin
                next_state.gen_write = 1'b1;
                next_state.gen_wdata = state.acc[7:0];
              end
              op_store_a_dir:
              begin
                next_state.mem_write = 1'b1;
                next_state.mem_addr = {8'h00, state.byte_op};
                next_state.mem_data = state.acc[7:0];
              end
              op_store_a_ext:
              begin
                next_state.mem_write = 1'b1;
                next_state.mem_addr = state.word_op;
                next_state.mem_data = state.acc[7:0];
              end
              op_store_a_index:
              begin
                next_state.mem_write = 1'b1;
                next_state.mem_addr = state.index_register + {8'h00, state.byte_op};
                next_state.mem_data = state.acc[7:0];
              end
              op_store_a_extra:
              begin
                next_state.mem_write = 1'b1;
                next_state.mem_addr = state.extra_pointer;
                next_state.mem_data = state.acc[7:0];
              end
              op_bit_addr:
              begin
                next_state.mem_addr = {8'h00, state.byte_op};
                next_state.mem_bit = state.bit_pos;
              end
              op_add_a_imm8:
              begin
                // byte add, all four arithmetic flags updated
                next_state.acc[7:0] = add_sum[7:0];
                next_state.flags[FLAG_N] = add_sum[7];
                next_state.flags[FLAG_Z] = (add_sum[7:0] == 8'h00);
                next_state.flags[FLAG_C] = add_sum[8];
                next_state.flags[FLAG_V] = (state.acc[7] == state.byte_op[7])
                  && (add_sum[7] != state.acc[7]);
              end
              op_movw_ix_imm16: next_state.index_register = state.word_op;
              op_movw_ep_imm16: next_state.extra_pointer = state.word_op;
              op_movw_sp_a: next_state.stack_pointer = state.acc;
              op_set_bank: next_state.bank_select_pointer = state.bank_in;
              op_branch_rel:
              begin
                // signed displacement from the current program counter
                next_state.program_counter = state.program_counter
                  + {{8{state.byte_op[7]}}, state.byte_op};
              end
              default:
              begin
                next_state.phase = st_idle;
              end
            endcase
          end
        end
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= '0;
      state.phase <= st_idle;
      state.op <= op_nop;
      state.vcall <= op_vector_off;
      state.acc <= WORD_RESET;
      state.hold <= WORD_RESET;
      state.index_register <= WORD_RESET;
      state.extra_pointer <= WORD_RESET;
      state.program_counter <= PC_RESET;
      state.stack_pointer <= SP_RESET;
      state.flags <= FLAGS_RESET;
      state.bank_select_pointer <= BANK_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign o_ready = (state.phase == st_idle);
  assign o_done = state.done;
  assign o_inst_tick = state.inst_tick;
  assign o_serial_shift_clock = state.shift_clock;
  assign o_sum_high_byte = state.acc[15:8];
  assign o_sum_low_byte = state.acc[7:0];
  assign o_hold_high_byte = state.hold[15:8];
  assign o_hold_low_byte = state.hold[7:0];
  assign o_index_register = state.index_register;
  assign o_extra_pointer = state.extra_pointer;
  assign o_program_counter = state.program_counter;
  assign o_stack_pointer = state.stack_pointer;
  assign o_program_status = {state.bank_select_pointer, 3'h0, state.flags};
  assign o_condition_flags = state.flags;
  assign o_bank_select_pointer = state.bank_select_pointer;
  assign o_mem_write = state.mem_write;
  assign o_mem_addr = state.mem_addr;
  assign o_mem_data = state.mem_data;
  assign o_bit_pos = state.mem_bit;
endmodule
`default_nettype wire

// ==== core/cpu_operand_pkg.sv ====
// package with widths, reset values, flag layout and command codes of the operand model
package cpu_operand_pkg;
  // ==========================================================
  // operand field widths
  localparam int DIR_WIDTH = 8;
  localparam int BIT_POS_WIDTH = 3;
  localparam int VECTOR_WIDTH = 3;
  localparam int REL_WIDTH = 8;
  localparam int BANK_WIDTH = 5;
  localparam int REG_INDEX_WIDTH = 3;
  localparam int BYTE_WIDTH = 8;
  localparam int WORD_WIDTH = 16;
  localparam int GEN_ADDR_WIDTH = BANK_WIDTH + REG_INDEX_WIDTH;
  // ==========================================================
  // instruction cycle lengths in main clock periods
  localparam logic [6:0] CYCLE_DIV_0 = 7'h04;
  localparam logic [6:0] CYCLE_DIV_1 = 7'h08;
  localparam logic [6:0] CYCLE_DIV_2 = 7'h10;
  localparam logic [6:0] CYCLE_DIV_3 = 7'h40;
  // ==========================================================
  // condition flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  // ==========================================================
  // reset values and vector table placement
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [4:0] BANK_RESET = 5'h00;
  localparam logic [15:0] VECTOR_BASE = 16'hFFC0;
  localparam logic [15:0] STACK_STEP = 16'h0002;
  // ==========================================================
  // commands accepted on the operation port
  typedef enum logic [3:0] {
    op_nop,
    op_mov_a_imm8,
    op_movw_a_imm16,
    op_mov_a_ri,
    op_mov_ri_a,
    op_store_a_dir,
    op_store_a_ext,
    op_store_a_index,
    op_store_a_extra,
    op_bit_addr,
    op_add_a_imm8,
    op_movw_ix_imm16,
    op_movw_ep_imm16,
    op_movw_sp_a,
    op_set_bank,
    op_branch_rel
  } op_type;
  typedef enum logic [0:0] {
    op_vector_off,
    op_vector_on
  } vector_type;
endpackage

// ==== core/bank_reg_mem.sv ====
// banked general register storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module bank_reg_mem #(
  parameter int ADDR_WIDTH = 8,
  parameter int DATA_WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic [ADDR_WIDTH-1:0] i_addr,
  input wire logic i_wr_en,
  input wire logic [DATA_WIDTH-1:0] i_wr_data,
  output logic [DATA_WIDTH-1:0] o_rd_data
);
  logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

  // ==========================================================
  // write port and registered read port
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_addr];
  end
endmodule
`default_nettype wire

// ==== tb/cpu_operand_model_sva.sv ====
// checker of handshake, divider and flag relations of the operand model
`timescale 1ns/10ps
`default_nettype none
module cpu_operand_model_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire cpu_operand_pkg::op_type i_op,
  input wire cpu_operand_pkg::vector_type i_vector_call,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_inst_tick,
  input wire logic o_serial_shift_clock,
  input wire logic [7:0] o_condition_flags,
  input wire logic [15:0] o_program_status,
  input wire logic [4:0] o_bank_select_pointer,
  input wire logic o_mem_write
);
  import cpu_operand_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // command handshake
  AST_TAKE_DROP: assert property (o_ready && i_op_valid && i_vector_call == op_vector_on |=> !o_ready ##[2:66] o_done)
    else $error("vector call not completed in time");
  AST_DONE_BOUND: assert property (o_ready && i_op_valid && i_op == op_mov_a_imm8 |-> ##[3:67] o_done)
    else $error("byte load not completed in time");
  AST_DONE_READY: assert property (o_done |-> o_ready)
    else $error("done without ready");
  AST_STORE_DONE: assert property (o_mem_write |-> o_done)
    else $error("store outside done cycle");
  // ==========================================================
  // divider and shift clock
  AST_TICK_PULSE: assert property (o_inst_tick |=> !o_inst_tick [*3])
    else $error("tick spacing below four clocks");
  AST_SCK_HALF: assert property ($changed(o_serial_shift_clock) |=> $stable(o_serial_shift_clock) [*3])
    else $error("shift clock half period too short");
  AST_SCK_TICK: assert property ($changed(o_serial_shift_clock) |-> o_inst_tick || $past(o_inst_tick))
    else $error("shift clock moved without tick");
  // ==========================================================
  // flags and status
  AST_PS_LAYOUT: assert property (o_program_status == {o_bank_select_pointer, 3'h0, o_condition_flags})
    else $error("status word layout wrong");
  AST_FLAG_SPARE: assert property (o_condition_flags[7:4] == 4'h0)
    else $error("spare flag bits set");
  AST_FLAG_HOLD: assert property (!o_done |-> $stable(o_condition_flags))
    else $error("flags moved outside execution");
  COV_STORE: cover property (o_mem_write);
  COV_SCK: cover property ($changed(o_serial_shift_clock));
  COV_BANK: cover property (o_done && o_bank_select_pointer == 5'h1F);
endmodule
bind cpu_operand_model cpu_operand_model_sva chk (.i_clk, .i_rst, .i_op_valid, .i_op,
  .i_vector_call, .o_ready, .o_done, .o_inst_tick, .o_serial_shift_clock, .o_condition_flags,
  .o_program_status, .o_bank_select_pointer, .o_mem_write);
`default_nettype wire

// ==== tb/cpu_operand_model_tb.sv ====
// self-checking bench of the operand model
`timescale 1ns/10ps
`default_nettype none
module cpu_operand_model_tb;
  import cpu_operand_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, i_op_valid = 1'b0;
  logic [1:0] i_cycle_select = 2'h0;
  op_type i_op = op_nop;
  vector_type i_vector_call = op_vector_off;
  logic [7:0] i_byte_operand = 8'h00;
  logic [15:0] i_word_operand = 16'h0000;
  logic [2:0] i_reg_index = 3'h0, i_bit_pos = 3'h0, i_vector = 3'h0;
  logic [4:0] i_bank = 5'h00;
  logic o_ready, o_done, o_inst_tick, o_serial_shift_clock, o_mem_write;
  logic [7:0] o_sum_high_byte, o_sum_low_byte, o_hold_high_byte, o_hold_low_byte;
  logic [15:0] o_index_register, o_extra_pointer, o_program_counter, o_stack_pointer;
  logic [15:0] o_program_status, o_mem_addr;
  logic [7:0] o_condition_flags, o_mem_data;
  logic [4:0] o_bank_select_pointer;
  logic [2:0] o_bit_pos;
  int fail_count = 0, total_checks = 0, cyc = 0;
  cpu_operand_model dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_cycle_select(i_cycle_select),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_vector_call(i_vector_call),
    .i_byte_operand(i_byte_operand), .i_word_operand(i_word_operand),
    .i_reg_index(i_reg_index), .i_bit_pos(i_bit_pos), .i_vector(i_vector), .i_bank(i_bank),
    .o_ready(o_ready), .o_done(o_done), .o_inst_tick(o_inst_tick),
    .o_serial_shift_clock(o_serial_shift_clock),
    .o_sum_high_byte(o_sum_high_byte), .o_sum_low_byte(o_sum_low_byte),
    .o_hold_high_byte(o_hold_high_byte), .o_hold_low_byte(o_hold_low_byte),
    .o_index_register(o_index_register), .o_extra_pointer(o_extra_pointer),
    .o_program_counter(o_program_counter), .o_stack_pointer(o_stack_pointer),
    .o_program_status(o_program_status), .o_condition_flags(o_condition_flags),
    .o_bank_select_pointer(o_bank_select_pointer), .o_mem_write(o_mem_write),
    .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .o_bit_pos(o_bit_pos)
  );
  // ==========================================================
  // clock and hang guard
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      final_report;
    end
  end
  // ==========================================================
  // shared tasks
  task chk(input logic [19:0] s, input logic [19:0] e);
    begin
      total_checks++;
      if (s !== e)
      begin
        fail_count++;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // issue one command and wait for its done pulse
  task cmd(input op_type o, input vector_type v);
    int n;
    begin
      @(posedge i_clk);
      #10;
      i_op = o;
      i_vector_call = v;
      i_op_valid = 1'b1;
      @(posedge i_clk);
      #10;
      i_op_valid = 1'b0;
      i_vector_call = op_vector_off;
      n = 0;
      while (o_done !== 1'b1 && n < 100)
      begin
        @(posedge i_clk);
        #10;
        n++;
      end
      chk(n <= 6, 1'b1);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_load;
    begin
      i_byte_operand = 8'h80;
      cmd(op_mov_a_imm8, op_vector_off);
      chk({o_sum_low_byte, o_condition_flags}, 16'h8008);
      i_byte_operand = 8'h00;
      cmd(op_mov_a_imm8, op_vector_off);
      chk(o_condition_flags, 8'h04);
      i_byte_operand = 8'h7F;
      cmd(op_mov_a_imm8, op_vector_off);
      i_byte_operand = 8'h01;
      cmd(op_add_a_imm8, op_vector_off);
      chk({o_sum_low_byte, o_condition_flags}, 16'h800A);
    end
  endtask
  task t_store;
    begin
      i_word_operand = 16'hA55A;
      cmd(op_movw_a_imm16, op_vector_off);
      chk({o_sum_high_byte, o_sum_low_byte}, 16'hA55A);
      chk({o_hold_high_byte, o_hold_low_byte}, 16'h0080);
      i_byte_operand = 8'h3C;
      cmd(op_store_a_dir, op_vector_off);
      chk({o_mem_write, o_mem_data, o_condition_flags}, 17'h15A0A);
      chk(o_mem_addr, 16'h003C);
      i_word_operand = 16'hBEEF;
      cmd(op_store_a_ext, op_vector_off);
      chk(o_mem_addr, 16'hBEEF);
      i_word_operand = 16'h1000;
      cmd(op_movw_ix_imm16, op_vector_off);
      chk(o_index_register, 16'h1000);
      i_byte_operand = 8'hF0;
      cmd(op_store_a_index, op_vector_off);
      chk(o_mem_addr, 16'h10F0);
      i_word_operand = 16'h2222;
      cmd(op_movw_ep_imm16, op_vector_off);
      cmd(op_store_a_extra, op_vector_off);
      chk(o_mem_addr, 16'h2222);
      chk(o_extra_pointer, 16'h2222);
      i_byte_operand = 8'h55;
      i_bit_pos = 3'h5;
      cmd(op_bit_addr, op_vector_off);
      chk({o_mem_addr, o_bit_pos}, 19'h002AD);
    end
  endtask
  task t_bank;
    begin
      i_bank = 5'h1F;
      cmd(op_set_bank, op_vector_off);
      chk(o_program_status, 16'hF80A);
      i_reg_index = 3'h7;
      cmd(op_mov_ri_a, op_vector_off);
      i_byte_operand = 8'h00;
      cmd(op_mov_a_imm8, op_vector_off);
      chk(o_condition_flags, 8'h06);
      cmd(op_mov_a_ri, op_vector_off);
      chk({o_sum_low_byte, o_condition_flags}, 16'h5A02);
    end
  endtask
  task t_flow;
    begin
      cmd(op_movw_sp_a, op_vector_off);
      chk(o_stack_pointer, 16'hA55A);
      i_vector = 3'h3;
      cmd(op_nop, op_vector_on);
      chk(o_program_counter, 16'hFFC6);
      i_vector = 3'h7;
      cmd(op_nop, op_vector_on);
      chk({o_program_counter ^ o_stack_pointer}, 16'hFFCE ^ 16'hA556);
      i_byte_operand = 8'hFE;
      cmd(op_branch_rel, op_vector_off);
      chk(o_program_counter, 16'hFFCC);
    end
  endtask
  // count clocks between ticks and between shift clock edges
  task t_period(input logic [1:0] s, input logic [15:0] e);
    int n, k;
    logic v;
    begin
      i_cycle_select = s;
      for (k = 0; k < 3; k++)
      begin
        n = 0;
        v = o_serial_shift_clock;
        do
        begin
          @(posedge i_clk);
          #10;
          n++;
        end
        while (o_inst_tick !== 1'b1 && n < 100);
      end
      chk(n, e);
      n = 0;
      while (o_serial_shift_clock === v && n < 200)
      begin
        @(posedge i_clk);
        #10;
        n++;
      end
      v = o_serial_shift_clock;
      n = 0;
      while (o_serial_shift_clock === v && n < 200)
      begin
        @(posedge i_clk);
        #10;
        n++;
      end
      chk(n, e);
    end
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    #10;
    i_rst = 1'b0;
    chk({o_ready, o_program_counter}, 17'h10000);
    chk(o_program_status, 16'h0000);
    t_load;
    t_store;
    t_bank;
    t_flow;
    t_period(2'h0, 16'h0004);
    t_period(2'h1, 16'h0008);
    t_period(2'h2, 16'h0010);
    t_period(2'h3, 16'h0040);
    final_report;
  end
endmodule
`default_nettype wire
